// *** nv_access_ctrl.sv ***
// cpu-side access controller for the byte-wide nonvolatile data store
// Notes on behaviour
// - store has its own address space, read one byte per access.
// - a read stalls the processor four clock cycles.
// - launching write or erase stalls the processor two clock cycles.
// - programming timed from oscillator; write 4.5 ms, erase 8.5 ms.
// - erase and write are self-timed; busy bit shows completion.
// - programming only via guarded two-step enable; other writes ignored.
// - mode 2 is write only; arm with mode, then set go.
// - launch write holds arm, go, mode; go counts only when armed.
// - mode 1 erases byte to all ones; software loads 0xff first.
// - setting read strobe puts addressed byte in data register next.
// - mode 3 loads data register into page buffer only.
// - 8-byte pages commit together with the command loading last byte.
// - page buffer clears after every write or erase and reset.
module nv_access_ctrl #(
  parameter int ADDR_W = 13,
  parameter int WRITE_CYCLES = nv_pkg::WRITE_CYCLES,
  parameter int ERASE_CYCLES = nv_pkg::ERASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_cpu_stall,
  output logic o_irq,
  input wire logic i_self_prog_busy
);
  typedef enum logic [1:0] {IDLE, LOAD_RUN, PROG_RUN} phase_type;

  typedef struct packed {
    phase_type phase;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic [1:0] mode;
    logic arm;
    logic [2:0] arm_cnt;
    logic go;
    logic [23:0] timer;
    logic [2:0] stall_cnt;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [7:0] rdata;
    logic irq;
    logic rd_pending;
    logic load;
    logic commit;
    logic stall;
  } state_type;

  localparam logic [23:0] WRITE_T = 24'(WRITE_CYCLES - 1);
  localparam logic [23:0] ERASE_T = 24'(ERASE_CYCLES - 1);
  localparam logic [23:0] ATOMIC_T = 24'(WRITE_CYCLES + ERASE_CYCLES - 1);
  localparam logic [23:0] LOAD_T = 24'(nv_pkg::LOAD_CYCLES - 1);

  state_type state_reg;
  state_type state_next;
  logic [7:0] store_rd_data;
  logic sp_busy_meta_reg;
  logic sp_busy_reg;

  function automatic logic [23:0] op_time(input logic [1:0] mode);
    case (mode)
      nv_pkg::MODE_ERASE: op_time = ERASE_T;
      nv_pkg::MODE_WRITE: op_time = WRITE_T;
      nv_pkg::MODE_LOAD: op_time = LOAD_T;
      default: op_time = ATOMIC_T;
    endcase
  endfunction : op_time

  // self-program busy comes from another block's timing; two-stage sync
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp_busy_meta_reg <= 1'b0;
      sp_busy_reg <= 1'b0;
    end else begin
      sp_busy_meta_reg <= i_self_prog_busy;
      sp_busy_reg <= sp_busy_meta_reg;
    end
  end

  nv_page_store #(
    .ADDR_W(ADDR_W),
    .PAGE_BYTES(nv_pkg::PAGE_BYTES)
  ) u_store (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_rd_addr(state_reg.addr),
    .o_rd_data(store_rd_data),
    .i_load(state_reg.load),
    .i_commit(state_reg.commit),
    .i_mode(state_reg.mode),
    .i_addr(state_reg.addr),
    .i_data(state_reg.data)
  );

  always_comb begin
    logic [7:0] ctrl_view;
    logic launch;
    logic [1:0] events;
    ctrl_view = 8'h00;
    launch = 1'b0;
    events = 2'b00;
    state_next = state_reg;
    state_next.load = 1'b0;
    state_next.commit = 1'b0;
    state_next.rd_pending = 1'b0;
    state_next.rdata = 8'h00;

    ctrl_view[nv_pkg::READ_STROBE_BIT] = 1'b0;
    ctrl_view[nv_pkg::GO_BUSY_BIT] = state_reg.go;
    ctrl_view[nv_pkg::ARM_BIT] = state_reg.arm;
    ctrl_view[nv_pkg::MODE_LSB +: 2] = state_reg.mode;

    if (state_reg.stall_cnt != 3'h0) begin
      state_next.stall_cnt = state_reg.stall_cnt - 3'h1;
    end

    // arm window expires on its own
    if (state_reg.arm) begin
      if (state_reg.arm_cnt == 3'h0) begin
        state_next.arm = 1'b0;
      end else begin
        state_next.arm_cnt = state_reg.arm_cnt - 3'h1;
      end
    end

    // byte read lands in the data register one cycle after the strobe
    if (state_reg.rd_pending) begin
      state_next.data = store_rd_data;
      events[nv_pkg::IRQ_READ_BIT] = 1'b1;
    end

    case (state_reg.phase)
      IDLE: begin
      end
      LOAD_RUN, PROG_RUN: begin
        if (state_reg.timer == 24'h0) begin
          state_next.phase = IDLE;
          state_next.go = 1'b0;
          events[nv_pkg::IRQ_DONE_BIT] = 1'b1;
          if (state_reg.phase == PROG_RUN) begin
            state_next.commit = 1'b1;
          end else begin
            state_next.load = 1'b1;
          end
        end else begin
          state_next.timer = state_reg.timer - 24'h1;
        end
      end
      default: state_next.phase = IDLE;
    endcase

    if (i_wr) begin
      case (i_addr)
        nv_pkg::ADDR_LOW_OFS: if (!state_reg.go) state_next.addr[7:0] = i_wdata;
        nv_pkg::ADDR_HIGH_OFS: if (!state_reg.go) begin
          state_next.addr[ADDR_W-1:8] = i_wdata[ADDR_W-9:0];
        end
        nv_pkg::DATA_OFS: if (!state_reg.go) state_next.data = i_wdata;
        nv_pkg::IRQ_MASK_OFS: state_next.irq_mask = i_wdata[1:0];
        nv_pkg::CTRL_OFS: begin
          // control writes are dropped while an operation runs
          if (!state_reg.go) begin
            if (!state_reg.arm) begin
              state_next.mode = i_wdata[nv_pkg::MODE_LSB +: 2];
            end
            if (i_wdata[nv_pkg::GO_BUSY_BIT] && state_reg.arm && !sp_busy_reg) begin
              launch = 1'b1;
            end else if (i_wdata[nv_pkg::ARM_BIT] && !state_reg.arm) begin
              state_next.arm = 1'b1;
              state_next.arm_cnt = 3'(nv_pkg::ARM_WINDOW_CYCLES - 1);
            end
            if (i_wdata[nv_pkg::READ_STROBE_BIT] && !launch) begin
              state_next.rd_pending = 1'b1;
              state_next.stall_cnt = 3'(nv_pkg::READ_STALL_CYCLES);
            end
          end
        end
        default: begin
        end
      endcase
    end

    if (launch) begin
      state_next.go = 1'b1;
      state_next.arm = 1'b0;
      state_next.timer = op_time(state_reg.mode);
      state_next.phase = (state_reg.mode == nv_pkg::MODE_LOAD) ? LOAD_RUN : PROG_RUN;
      state_next.stall_cnt = 3'(nv_pkg::PROG_STALL_CYCLES);
    end

    if (i_rd) begin
      case (i_addr)
        nv_pkg::ADDR_LOW_OFS: state_next.rdata = state_reg.addr[7:0];
        nv_pkg::ADDR_HIGH_OFS: state_next.rdata = 8'(state_reg.addr[ADDR_W-1:8]);
        nv_pkg::DATA_OFS: state_next.rdata = state_reg.data;
        nv_pkg::CTRL_OFS: state_next.rdata = ctrl_view;
        nv_pkg::IRQ_STATUS_OFS: state_next.rdata = {6'h00, state_reg.irq_status};
        nv_pkg::IRQ_MASK_OFS: state_next.rdata = {6'h00, state_reg.irq_mask};
        nv_pkg::SELF_PROG_OFS: state_next.rdata = {7'h00, sp_busy_reg};
        default: state_next.rdata = 8'h00;
      endcase
    end

    // read clears status, but a new event in the same cycle survives
    if (i_rd && i_addr == nv_pkg::IRQ_STATUS_OFS) begin
      state_next.irq_status = events;
    end else begin
      state_next.irq_status = state_reg.irq_status | events;
    end
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
    // stall kept as its own flop so the pin has no decode glitches
    state_next.stall = (state_next.stall_cnt != 3'h0);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '{phase: IDLE, addr: '0, data: nv_pkg::RESET_BYTE,
                     mode: nv_pkg::MODE_ATOMIC, arm: 1'b0, arm_cnt: 3'h0,
                     go: 1'b0, timer: 24'h0, stall_cnt: 3'h0,
                     irq_status: 2'h0, irq_mask: 2'h0, rdata: 8'h00,
                     irq: 1'b0, rd_pending: 1'b0, load: 1'b0, commit: 1'b0,
                     stall: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_irq = state_reg.irq;
  assign o_cpu_stall = state_reg.stall;
endmodule : nv_access_ctrl

// *** nv_access_ctrl_sva.sv ***
// port-level checks for the nonvolatile store access controller
module nv_access_ctrl_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_cpu_stall,
  input wire logic o_irq,
  input wire logic i_self_prog_busy
);
  logic ctrl_wr;
  logic go_wr;
  logic irq_clr;
  logic [2:0] arm_age_reg;
  logic [2:0] stall_run_reg;
  logic [2:0] clr_hist_reg;
  logic [2:0] sp_hist_reg;
  assign ctrl_wr = i_wr && i_addr == nv_pkg::CTRL_OFS;
  assign go_wr = ctrl_wr && i_wdata[2:1] == 2'b11;
  assign irq_clr = (i_rd && i_addr == nv_pkg::IRQ_STATUS_OFS) ||
                   (i_wr && i_addr == nv_pkg::IRQ_MASK_OFS);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // age 1..4 is the open arm window, 5 means it ran out
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      arm_age_reg <= 3'h0;
      stall_run_reg <= 3'h0;
      clr_hist_reg <= 3'h0;
      sp_hist_reg <= 3'h0;
    end else begin
      // any control write with arm set opens a window when none is open
      if (ctrl_wr && i_wdata[2] && !(arm_age_reg inside {[3'h1:3'h4]}))
        arm_age_reg <= 3'h1;
      else if (arm_age_reg != 3'h0 && arm_age_reg != 3'h5)
        arm_age_reg <= arm_age_reg + 3'h1;
      if (!o_cpu_stall)
        stall_run_reg <= 3'h0;
      else if (stall_run_reg != 3'h7)
        stall_run_reg <= stall_run_reg + 3'h1;
      clr_hist_reg <= {clr_hist_reg[1:0], irq_clr};
      sp_hist_reg <= {sp_hist_reg[1:0], i_self_prog_busy};
    end
  end
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside its slot");
  unmapped_zero_a: assert property ($past(i_rd) && $past(i_addr) == 3'h7 |-> o_rdata == 8'h00)
    else $error("unmapped offset read not zero");
  read_stall_a: assert property (ctrl_wr && i_wdata == 8'h01 && !o_cpu_stall |=>
    o_cpu_stall [*4] ##1 !o_cpu_stall) else $error("read stall not four cycles");
  launch_stall_a: assert property (go_wr && arm_age_reg inside {[1:4]} && !o_cpu_stall &&
    sp_hist_reg == 3'h0 && !i_self_prog_busy |=> o_cpu_stall [*2] ##1 !o_cpu_stall)
    else $error("launch stall not two cycles");
  stale_go_a: assert property (go_wr && !(arm_age_reg inside {[1:4]}) && !o_cpu_stall
    |=> !o_cpu_stall) else $error("go accepted without live arm");
  selfprog_block_a: assert property (go_wr && &sp_hist_reg && i_self_prog_busy &&
    !o_cpu_stall |=> !o_cpu_stall) else $error("launch during self program");
  stall_bound_a: assert property (stall_run_reg <= 3'h4)
    else $error("stall longer than four cycles");
  irq_fall_a: assert property ($fell(o_irq) |-> clr_hist_reg != 3'h0)
    else $error("interrupt dropped with no clear");
endmodule : nv_access_ctrl_chk

bind nv_access_ctrl nv_access_ctrl_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_cpu_stall(o_cpu_stall), .o_irq(o_irq), .i_self_prog_busy(i_self_prog_busy));

// *** nv_page_store.sv ***
// page buffer plus storage array of the nonvolatile data store
module nv_page_store #(
  parameter int ADDR_W = 13,
  parameter int PAGE_BYTES = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  input wire logic i_load,
  input wire logic i_commit,
  input wire logic [1:0] i_mode,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_data
);
  localparam int SLOT_W = $clog2(PAGE_BYTES);
  localparam int PAGE_W = ADDR_W - SLOT_W;

  logic [7:0] array_mem [2**ADDR_W];
  logic [7:0] buf_data [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] buf_valid;
  logic [PAGE_W-1:0] page;
  logic [SLOT_W-1:0] slot;

  // byte that a commit stores in one slot: the addressed byte wins over the buffer
  function automatic logic [7:0] commit_byte(input int idx);
    commit_byte = (idx == int'(slot)) ? i_data : buf_data[idx];
  endfunction : commit_byte

  assign page = i_addr[ADDR_W-1:SLOT_W];
  assign slot = i_addr[SLOT_W-1:0];
  assign o_rd_data = array_mem[i_rd_addr];

  // buffer flags reset; cleared after every commit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      buf_valid <= '0;
    end else if (i_commit) begin
      buf_valid <= '0;
    end else if (i_load) begin
      buf_valid[slot] <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_load) begin
      buf_data[slot] <= i_data;
    end
  end

  // commit writes every buffered byte of the page plus the addressed one
  always_ff @(posedge i_clk) begin
    if (i_commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if ((i == int'(slot)) || buf_valid[i]) begin
          case (i_mode)
            nv_pkg::MODE_ERASE: array_mem[{page, SLOT_W'(i)}] <= nv_pkg::ERASED_BYTE;
            nv_pkg::MODE_WRITE: array_mem[{page, SLOT_W'(i)}] <=
                array_mem[{page, SLOT_W'(i)}] & commit_byte(i);
            default: array_mem[{page, SLOT_W'(i)}] <= commit_byte(i);
          endcase
        end
      end
    end
  end
endmodule : nv_page_store

// *** nv_pkg.sv ***
// shared constants and carriers for the nonvolatile store access controller
package nv_pkg;
  localparam logic [2:0] ADDR_LOW_OFS = 3'h0;
  localparam logic [2:0] ADDR_HIGH_OFS = 3'h1;
  localparam logic [2:0] DATA_OFS = 3'h2;
  localparam logic [2:0] CTRL_OFS = 3'h3;
  localparam logic [2:0] IRQ_STATUS_OFS = 3'h4;
  localparam logic [2:0] IRQ_MASK_OFS = 3'h5;
  localparam logic [2:0] SELF_PROG_OFS = 3'h6;
  // control register fields
  localparam int READ_STROBE_BIT = 0;
  localparam int GO_BUSY_BIT = 1;
  localparam int ARM_BIT = 2;
  localparam int MODE_LSB = 4;
  // program mode field codes
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;
  localparam logic [1:0] MODE_LOAD = 2'h3;
  // interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_READ_BIT = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // timing
  localparam int CLK_MHZ = 125;
  localparam int READ_STALL_CYCLES = 4;
  localparam int PROG_STALL_CYCLES = 2;
  localparam int ARM_WINDOW_CYCLES = 4;
  localparam int WRITE_TIME_US = 4500;
  localparam int ERASE_TIME_US = 8500;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int LOAD_CYCLES = 2;
  localparam int PAGE_BYTES = 8;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] slot;
  } page_cmd_type;
endpackage : nv_pkg

// *** test_nv_access_ctrl.sv ***
// self-checking bench for the nonvolatile store access controller
module test_nv_access_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sp_busy = 1'b0;
  logic [7:0] rdata;
  logic stall;
  logic irq;
  logic [7:0] rd_seen;
  logic irq_seen;
  logic [7:0] v;
  int stall_cnt = 0;
  int mismatches = 0;
  int checks_done = 0;
  always #4 i_clk = ~i_clk;
  nv_access_ctrl #(.WRITE_CYCLES(20), .ERASE_CYCLES(30)) u_dut (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_cpu_stall(stall), .o_irq(irq), .i_self_prog_busy(sp_busy));
  // sample mid-cycle so edge updates have landed
  always @(negedge i_clk) begin
    rd_seen = rdata;
    irq_seen = irq;
    if (stall) stall_cnt++;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // every call sets all strobes, so back-to-back calls never drive twice
  task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w, input logic r);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= r;
    @(posedge i_clk);
  endtask : bus
  task automatic idle(input int n);
    repeat (n) bus(3'h0, 8'h00, 1'b0, 1'b0);
  endtask : idle
  task automatic rd_val(input logic [2:0] a, output logic [7:0] val);
    bus(a, 8'h00, 1'b0, 1'b1);
    idle(1);
    val = rd_seen;
  endtask : rd_val
  task automatic launch(input logic [7:0] a, input logic [7:0] d, input logic [1:0] m);
    bus(nv_pkg::ADDR_LOW_OFS, a, 1'b1, 1'b0);
    bus(nv_pkg::DATA_OFS, d, 1'b1, 1'b0);
    bus(nv_pkg::CTRL_OFS, {2'h0, m, 4'h4}, 1'b1, 1'b0);
    stall_cnt = 0;
    bus(nv_pkg::CTRL_OFS, {2'h0, m, 4'h6}, 1'b1, 1'b0);
    idle(3);
    if (m != nv_pkg::MODE_LOAD)
      chk(8'(stall_cnt), 8'h02, "launch stall");
  endtask : launch
  task automatic wait_done(input int cyc);
    logic [7:0] c;
    int polls;
    polls = 0;
    do begin
      rd_val(nv_pkg::CTRL_OFS, c);
      if (polls == 0 && cyc > 0) chk(c & 8'h02, 8'h02, "busy set");
      polls++;
    end while (c[nv_pkg::GO_BUSY_BIT] !== 1'b0 && polls < 300);
    chk(c & 8'h02, 8'h00, "busy clears");
    if (cyc > 0)
      chk(8'(polls >= cyc / 2 - 2 && polls <= cyc / 2 + 2), 8'h01, "op time");
    idle(1);
  endtask : wait_done
  task automatic rd_byte(input logic [7:0] a, input logic [7:0] exp);
    bus(nv_pkg::ADDR_LOW_OFS, a, 1'b1, 1'b0);
    stall_cnt = 0;
    bus(nv_pkg::CTRL_OFS, 8'h01, 1'b1, 1'b0);
    idle(2);
    rd_val(nv_pkg::DATA_OFS, v);
    chk(8'(stall_cnt), 8'h04, "read stall");
    chk(v, exp, "stored byte");
  endtask : rd_byte
  initial begin
    #200us;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      rd_val(3'(i), v);
      chk(v, 8'h00, "reset value");
    end
    bus(nv_pkg::ADDR_HIGH_OFS, 8'h00, 1'b1, 1'b0);
    bus(nv_pkg::IRQ_MASK_OFS, 8'h01, 1'b1, 1'b0);
    $display("test reset done");
    launch(8'h08, 8'hff, nv_pkg::MODE_ERASE);
    wait_done(30);
    chk({7'h0, irq_seen}, 8'h01, "irq on done");
    rd_val(nv_pkg::IRQ_STATUS_OFS, v);
    chk(v, 8'h01, "status");
    rd_val(nv_pkg::IRQ_STATUS_OFS, v);
    chk(v, 8'h00, "status cleared");
    chk({7'h0, irq_seen}, 8'h00, "irq cleared");
    rd_byte(8'h08, 8'hff);
    launch(8'h08, 8'h3c, nv_pkg::MODE_WRITE);
    wait_done(20);
    rd_byte(8'h08, 8'h3c);
    launch(8'h08, 8'hf0, nv_pkg::MODE_WRITE);
    wait_done(20);
    rd_val(nv_pkg::IRQ_STATUS_OFS, v);
    chk(v, 8'h03, "done and read status");
    rd_byte(8'h08, 8'h30);
    chk({7'h0, irq_seen}, 8'h00, "masked event");
    $display("test program done");
    for (int k = 0; k < 3; k++) begin
      sp_busy <= (k == 2);
      idle(3);
      if (k > 0) bus(nv_pkg::CTRL_OFS, 8'h24, 1'b1, 1'b0);
      idle(k == 1 ? 5 : 0);
      bus(nv_pkg::CTRL_OFS, 8'h26, 1'b1, 1'b0);
      rd_val(nv_pkg::CTRL_OFS, v);
      chk(v & 8'h02, 8'h00, "go refused");
    end
    sp_busy <= 1'b0;
    idle(3);
    rd_byte(8'h08, 8'h30);
    launch(8'h09, 8'h5a, nv_pkg::MODE_ATOMIC);
    bus(nv_pkg::DATA_OFS, 8'h11, 1'b1, 1'b0);
    wait_done(0);
    rd_val(nv_pkg::DATA_OFS, v);
    chk(v, 8'h5a, "write while busy");
    $display("test guard done");
    for (int i = 0; i < 7; i++) begin
      launch(8'h10 + 8'(i), 8'h80 + 8'(i), nv_pkg::MODE_LOAD);
      wait_done(0);
    end
    launch(8'h17, 8'h87, nv_pkg::MODE_ATOMIC);
    wait_done(0);
    rd_byte(8'h10, 8'h80);
    launch(8'h13, 8'h11, nv_pkg::MODE_LOAD);
    wait_done(0);
    rd_byte(8'h13, 8'h83);
    launch(8'h12, 8'h44, nv_pkg::MODE_ATOMIC);
    wait_done(0);
    rd_byte(8'h13, 8'h11);
    launch(8'h13, 8'h22, nv_pkg::MODE_ATOMIC);
    wait_done(0);
    launch(8'h17, 8'h55, nv_pkg::MODE_ATOMIC);
    wait_done(0);
    rd_byte(8'h12, 8'h44);
    rd_byte(8'h13, 8'h22);
    // a reset between a finished load and the commit must empty the page buffer but keep the array
    launch(8'h14, 8'h66, nv_pkg::MODE_LOAD);
    wait_done(0);
    i_rst_n <= 1'b0;
    idle(2);
    i_rst_n <= 1'b1;
    idle(2);
    rd_val(nv_pkg::CTRL_OFS, v);
    chk(v, 8'h00, "control after reset");
    launch(8'h17, 8'h77, nv_pkg::MODE_ATOMIC);
    wait_done(0);
    rd_byte(8'h14, 8'h84);
    $display("test page done");
    complete_run();
  end
endmodule : test_nv_access_ctrl
